// >>> cmh_pkg.sv
// Constants, types and command codes of the configuration-mode command handler
// Function
// - Strength command returns byte then prompt
// - Strength byte counts half-decibel steps
// - Strength reply is an instantaneous sample
// - Packet header carries first-hop strength
// - Temperature command returns byte then prompt
// - Temperature equals byte minus 128
// - Supply command returns byte then prompt
// - Supply byte counts 30 mV steps
// - Event packets carry temperature and supply
// - Memory write prompts, pairs get no reply
// - 0xFF address ends write, prompt later
// - Exit byte triggers full restart
// - Config pin pulse enters mode, prompt
// - Pin-wake sleep only while pin low
// - Pin-wake sleep until pin goes high
// - Pull-ups off during sleep
// - Serial-wake sleep until start bit
// - Serial-wake sleep ignores config pin
// - Key load: 0x4B, 0x37, prompt, 16 bytes
// - Key load aborts after ten second gap
// - Key store unreadable, unwritable by memory writes
// - Unknown command discarded, prompt resent
// - Calibration write uses same pair protocol
package cmh_pkg;

    // ****************************************************************
    // Command bytes
    // ****************************************************************
    localparam logic [7:0] CMD_STRENGTH   = 8'h53;
    localparam logic [7:0] CMD_TEMP       = 8'h55;
    localparam logic [7:0] CMD_SUPPLY     = 8'h56;
    localparam logic [7:0] CMD_MEM_WRITE  = 8'h4D;
    localparam logic [7:0] CMD_EXIT       = 8'h58;
    localparam logic [7:0] CMD_SLEEP_PIN  = 8'h5A;
    localparam logic [7:0] CMD_SLEEP_RX   = 8'h7A;
    localparam logic [7:0] CMD_KEY        = 8'h4B;
    localparam logic [7:0] KEY_INDEX      = 8'h37;
    localparam logic [7:0] CMD_CAL_1      = 8'h48;
    localparam logic [7:0] CMD_CAL_2      = 8'h57;
    localparam logic [7:0] WRITE_END      = 8'hFF;
    localparam logic [7:0] PROMPT_CHAR    = 8'h3E;

    // ****************************************************************
    // Sizes and timing
    // ****************************************************************
    localparam int unsigned KEY_BYTES      = 16;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned KEY_GAP_S      = 10;
    localparam int unsigned KEY_GAP_CYC    = KEY_GAP_S * CLK_HZ;
    localparam int unsigned MEM_CFG_US     = 100;
    localparam int unsigned MEM_CFG_CYC    = (MEM_CFG_US * (CLK_HZ / 1_000_000));
    localparam int unsigned TIMER_W        = 28;
    localparam logic [3:0]  KEY_CNT_RESET  = 4'h0;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD, ST_CAL2, ST_KEYIDX, ST_KEYDATA,
        ST_ADDR, ST_DATA, ST_COMMIT, ST_SLEEP_PIN, ST_SLEEP_RX, ST_RESTART
    } cmh_state_type;

    // One memory write pair handed to the storage side
    typedef struct packed {
        logic       cal;
        logic [7:0] addr;
        logic [7:0] data;
    } cmh_wr_type;

    // Sensor readings, sampled live
    typedef struct packed {
        logic [7:0] strength;
        logic [7:0] temp;
        logic [7:0] supply;
    } cmh_sense_type;

endpackage

// >>> cmh_handler.sv
// Configuration-mode command interpreter of the mesh radio module
`timescale 1ns/1ps
module cmh_handler
    import cmh_pkg::*;
#(
    parameter int unsigned KEY_GAP_CYCLES = KEY_GAP_CYC,
    parameter int unsigned MEM_CFG_CYCLES = MEM_CFG_CYC
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          config_pin_i,
    input  wire logic          rxd_pin_i,
    input  wire logic          rx_valid_i,
    input  wire logic [7:0]    rx_data_i,
    input  wire logic          tx_ready_i,
    input  wire cmh_sense_type sense_i,
    input  wire logic          commit_done_i,
    output logic               tx_valid_o,
    output logic [7:0]         tx_data_o,
    output logic               wr_valid_o,
    output cmh_wr_type         wr_o,
    output logic               commit_o,
    output logic               key_valid_o,
    output logic [7:0]         key_data_o,
    output logic [3:0]         key_index_o,
    output logic               key_done_o,
    output logic               key_abort_o,
    output logic               sleep_o,
    output logic               pullup_en_o,
    output logic               restart_o,
    output logic               cfg_mode_o
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic cfg_s1_reg;
    logic cfg_s2_reg;
    logic cfg_s3_reg;
    logic rxd_s1_reg;
    logic rxd_s2_reg;
    logic rxd_s3_reg;

    // Two flops per pin, third for edge detection
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_s1_reg <= 1'b1;
            cfg_s2_reg <= 1'b1;
            cfg_s3_reg <= 1'b1;
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
            rxd_s3_reg <= 1'b1;
        end else begin
            cfg_s1_reg <= config_pin_i;
            cfg_s2_reg <= cfg_s1_reg;
            cfg_s3_reg <= cfg_s2_reg;
            rxd_s1_reg <= rxd_pin_i;
            rxd_s2_reg <= rxd_s1_reg;
            rxd_s3_reg <= rxd_s2_reg;
        end
    end

    logic cfg_rise;
    logic rxd_fall;
    assign cfg_rise = cfg_s2_reg & ~cfg_s3_reg;   // Pin released (active low)
    assign rxd_fall = ~rxd_s2_reg & rxd_s3_reg;   // Start bit edge

    // ****************************************************************
    // Reply queue: one byte then optional prompt
    // ****************************************************************
    logic       tx_valid_reg;
    logic [7:0] tx_data_reg;
    logic       prompt_pend_reg;
    logic       send_byte;
    logic [7:0] send_data;
    logic       send_prompt;
    logic       tx_busy;

    assign tx_busy = tx_valid_reg | prompt_pend_reg;

    // Reading goes out first, prompt right behind it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_valid_reg    <= 1'b0;
            tx_data_reg     <= BYTE_RESET;
            prompt_pend_reg <= 1'b0;
        end else if (send_byte) begin
            tx_valid_reg    <= 1'b1;
            tx_data_reg     <= send_data;
            prompt_pend_reg <= send_prompt;
        end else if (tx_valid_reg && tx_ready_i) begin
            tx_valid_reg    <= prompt_pend_reg;
            tx_data_reg     <= PROMPT_CHAR;
            prompt_pend_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Command state machine
    // ****************************************************************
    cmh_state_type     state_reg;
    logic              cal_reg;
    logic [7:0]        addr_reg;
    logic [3:0]        key_cnt_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic              take;

    // A byte is consumed only when no reply is still queued
    assign take = rx_valid_i & ~tx_busy;

    // Decoder for the commands that reply with a live reading
    function automatic logic is_reading(input logic [7:0] b);
        return (b == CMD_STRENGTH) || (b == CMD_TEMP) || (b == CMD_SUPPLY);
    endfunction

    // Reply byte selection and enqueue strobes
    always_comb begin
        send_byte   = 1'b0;
        send_data   = PROMPT_CHAR;
        send_prompt = 1'b0;
        if (!tx_busy) begin
            unique case (state_reg)
                ST_IDLE: begin
                    send_byte = cfg_rise;
                end
                ST_CMD: begin
                    if (take) begin
                        if (is_reading(rx_data_i)) begin
                            send_byte   = 1'b1;
                            send_prompt = 1'b1;
                            // Live sample, no averaging
                            // Raw bytes, same format packets carry
                            send_data   = (rx_data_i == CMD_STRENGTH) ? sense_i.strength :
                                          (rx_data_i == CMD_TEMP) ? sense_i.temp :
                                          sense_i.supply;
                        end else if (rx_data_i == CMD_MEM_WRITE) begin
                            send_byte = 1'b1;
                        end else if (rx_data_i == CMD_SLEEP_PIN
                                     || rx_data_i == CMD_SLEEP_RX
                                     || rx_data_i == CMD_EXIT
                                     || rx_data_i == CMD_KEY
                                     || rx_data_i == CMD_CAL_1) begin
                            send_byte = 1'b0;
                        end else begin
                            send_byte = 1'b1;
                        end
                    end
                end
                ST_CAL2: send_byte = take;
                ST_KEYIDX: send_byte = take;
                ST_KEYDATA: send_byte = take && key_cnt_reg == 4'(KEY_BYTES - 1);
                ST_COMMIT: send_byte = commit_done_i
                                       && timer_reg >= TIMER_W'(MEM_CFG_CYCLES);
                default: send_byte = 1'b0;
            endcase
        end
    end

    // State transitions
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (cfg_rise && !tx_busy) state_reg <= ST_CMD;
                ST_CMD: begin
                    if (take) begin
                        unique case (rx_data_i)
                            CMD_MEM_WRITE: state_reg <= ST_ADDR;
                            CMD_CAL_1:     state_reg <= ST_CAL2;
                            CMD_KEY:       state_reg <= ST_KEYIDX;
                            CMD_EXIT:      state_reg <= ST_RESTART;
                            CMD_SLEEP_RX:  state_reg <= ST_SLEEP_RX;
                            CMD_SLEEP_PIN: if (!cfg_s2_reg) begin
                                state_reg <= ST_SLEEP_PIN;
                            end
                            default:       state_reg <= ST_CMD;
                        endcase
                    end
                end
                ST_CAL2: if (take) state_reg <= (rx_data_i == CMD_CAL_2) ? ST_ADDR : ST_CMD;
                ST_KEYIDX: if (take) state_reg <= (rx_data_i == KEY_INDEX) ? ST_KEYDATA : ST_CMD;
                ST_KEYDATA: begin
                    if (take && key_cnt_reg == 4'(KEY_BYTES - 1)) begin
                        state_reg <= ST_CMD;
                    end else if (!take && timer_reg >= TIMER_W'(KEY_GAP_CYCLES)) begin
                        state_reg <= ST_CMD;
                    end
                end
                ST_ADDR: if (take) state_reg <= (rx_data_i == WRITE_END) ? ST_COMMIT : ST_DATA;
                ST_DATA: if (take) state_reg <= ST_ADDR;
                ST_COMMIT: if (send_byte) state_reg <= ST_CMD;
                ST_SLEEP_PIN: if (cfg_s2_reg) state_reg <= ST_CMD;
                ST_SLEEP_RX: if (rxd_fall) state_reg <= ST_CMD;
                ST_RESTART: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Calibration flag, address latch, key counter
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cal_reg     <= 1'b0;
            addr_reg    <= BYTE_RESET;
            key_cnt_reg <= KEY_CNT_RESET;
        end else begin
            if (state_reg == ST_CMD && take) cal_reg <= (rx_data_i == CMD_CAL_1);
            if (state_reg == ST_ADDR && take) addr_reg <= rx_data_i;
            if (state_reg == ST_KEYIDX) key_cnt_reg <= KEY_CNT_RESET;
            else if (state_reg == ST_KEYDATA && take) key_cnt_reg <= key_cnt_reg + 4'h1;
        end
    end

    // Gap timer for key bytes, settle timer for commit
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_reg <= '0;
        end else if ((state_reg == ST_KEYDATA && !take) || state_reg == ST_COMMIT) begin
            if (timer_reg != '1) timer_reg <= timer_reg + TIMER_W'(1);
        end else begin
            timer_reg <= '0;
        end
    end

    // ****************************************************************
    // Storage and control outputs
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_valid_o  <= 1'b0;
            wr_o        <= '0;
            commit_o    <= 1'b0;
            key_valid_o <= 1'b0;
            key_data_o  <= BYTE_RESET;
            key_index_o <= KEY_CNT_RESET;
            key_done_o  <= 1'b0;
            key_abort_o <= 1'b0;
        end else begin
            // Pairs go only to config or calibration memory, never the key store
            wr_valid_o  <= state_reg == ST_DATA && take;
            wr_o        <= '{cal: cal_reg, addr: addr_reg, data: rx_data_i};
            commit_o    <= state_reg == ST_ADDR && take && rx_data_i == WRITE_END;
            key_valid_o <= state_reg == ST_KEYDATA && take;
            key_data_o  <= rx_data_i;
            key_index_o <= key_cnt_reg;
            key_done_o  <= state_reg == ST_KEYDATA && take
                           && key_cnt_reg == 4'(KEY_BYTES - 1);
            key_abort_o <= state_reg == ST_KEYDATA && !take
                           && timer_reg >= TIMER_W'(KEY_GAP_CYCLES);
        end
    end

    // Mode, sleep and restart outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sleep_o     <= 1'b0;
            pullup_en_o <= 1'b1;
            restart_o   <= 1'b0;
            cfg_mode_o  <= 1'b0;
        end else begin
            sleep_o     <= state_reg == ST_SLEEP_PIN || state_reg == ST_SLEEP_RX;
            pullup_en_o <= !(state_reg == ST_SLEEP_PIN || state_reg == ST_SLEEP_RX);
            restart_o   <= state_reg == ST_RESTART;
            cfg_mode_o  <= state_reg != ST_IDLE && state_reg != ST_RESTART;
        end
    end

    assign tx_valid_o = tx_valid_reg;
    assign tx_data_o  = tx_data_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_reading_prompt;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_CMD && take && is_reading(rx_data_i))
            |=> (tx_valid_o && prompt_pend_reg);
    endproperty
    a_reading_prompt: assert property (p_reading_prompt) else $error("no prompt after reading");

    property p_pin_sleep_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_CMD && take && rx_data_i == CMD_SLEEP_PIN && cfg_s2_reg)
            |=> state_reg == ST_CMD;
    endproperty
    a_pin_sleep_gate: assert property (p_pin_sleep_gate) else $error("sleep taken with pin high");

    property p_pin_wake;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_SLEEP_PIN && cfg_s2_reg) |=> state_reg == ST_CMD;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("no wake on pin high");

    property p_rx_wake;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_SLEEP_RX && !rxd_fall) |=> state_reg == ST_SLEEP_RX;
    endproperty
    a_rx_wake: assert property (p_rx_wake) else $error("woke without start bit");

    property p_pullups;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_CMD && take && rx_data_i == CMD_SLEEP_RX)
            |=> ##1 (sleep_o && !pullup_en_o);
    endproperty
    a_pullups: assert property (p_pullups) else $error("pull-ups on while asleep");

    property p_exit;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_CMD && take && rx_data_i == CMD_EXIT) |=> ##1 restart_o;
    endproperty
    a_exit: assert property (p_exit) else $error("exit gave no restart");

    property p_pair_silent;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_DATA && take) |=> !tx_valid_o;
    endproperty
    a_pair_silent: assert property (p_pair_silent) else $error("reply to pair byte");

    property p_key_abort;
        @(posedge clk_i) disable iff (!rst_n_i)
        key_abort_o |-> $past(state_reg) == ST_KEYDATA ##0 state_reg == ST_CMD;
    endproperty
    a_key_abort: assert property (p_key_abort) else $error("abort out of key load");

    // Prompt stands right after the reading byte is accepted
    property p_prompt_follows;
        @(posedge clk_i) disable iff (!rst_n_i)
        (tx_valid_o && tx_ready_i && prompt_pend_reg)
            |=> (tx_valid_o && tx_data_o == PROMPT_CHAR);
    endproperty
    a_prompt_follows: assert property (p_prompt_follows) else $error("prompt late");

    // Strength byte is the value present at the take
    property p_reading_data;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_CMD && take && rx_data_i == CMD_STRENGTH)
            |=> (tx_valid_o && tx_data_o == $past(sense_i.strength));
    endproperty
    a_reading_data: assert property (p_reading_data) else $error("stale strength");

    // Sixteenth key byte closes the load with a prompt
    property p_key_done;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_KEYDATA && take && key_cnt_reg == 4'(KEY_BYTES - 1))
            |=> (key_done_o && tx_valid_o && tx_data_o == PROMPT_CHAR);
    endproperty
    a_key_done: assert property (p_key_done) else $error("key load not closed");

endmodule // cmh_handler

// >>> cmh_host_model.sv
// Host-side model: feeds command bytes and collects reply bytes
`timescale 1ns/1ps
module cmh_host_model
    import cmh_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       slow_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            tx_ready_o
);
    logic [7:0] send_q[$];
    logic [7:0] recv_q[$];
    logic       taken;
    logic       got;
    logic [7:0] got_data;
    logic [7:0] last_data;

    // Idle levels at time zero
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'hA5;
        tx_ready_o = 1'b1;
        last_data  = 8'hA5;
    end

    // Byte exchange, one byte per take, replies kept in order
    always @(posedge clk_i) begin
        taken    = rx_valid_o && !tx_valid_i;
        got      = tx_valid_i && tx_ready_o;
        got_data = tx_data_i;
        #1;
        if (taken && send_q.size() > 0) begin
            last_data = send_q.pop_front();
        end
        if (got && rst_n_i) begin
            recv_q.push_back(got_data);
        end
        rx_valid_o = rst_n_i && (send_q.size() > 0);
        rx_data_o  = rx_valid_o ? send_q[0] : ~last_data; // Raw binary bytes
        tx_ready_o = slow_i ? ~tx_ready_o : 1'b1; // Stalling transmitter
    end
endmodule // cmh_host_model

// >>> tb_top.sv
// Self-checking bench of the configuration-mode command handler
`timescale 1ns/1ps
module tb_top;
    import cmh_pkg::*;
    localparam int unsigned GAP = 50;
    localparam int unsigned MCY = 5;
    typedef struct packed {
        logic [7:0]    cmd;
        cmh_sense_type sense;
        logic [7:0]    exp;
        logic          two;
    } cmh_row_type;

    logic          clk_i;
    logic          rst_n_i;
    logic          config_pin_i;
    logic          rxd_pin_i;
    logic          rx_valid;
    logic [7:0]    rx_data;
    logic          tx_ready;
    cmh_sense_type sense_i;
    logic          commit_done_i;
    logic          slow;
    logic          tx_valid_o;
    logic [7:0]    tx_data_o;
    logic          wr_valid_o;
    cmh_wr_type    wr_o;
    logic          commit_o;
    logic          key_valid_o;
    logic [7:0]    key_data_o;
    logic [3:0]    key_index_o;
    logic          key_done_o;
    logic          key_abort_o;
    logic          sleep_o;
    logic          pullup_en_o;
    logic          restart_o;
    logic          cfg_mode_o;
    cmh_wr_type    wr_q[$];
    logic [11:0]   key_q[$];
    int            commit_cnt = 0;
    int            done_cnt = 0;
    int            abort_cnt = 0;
    int            restart_cnt = 0;
    int            fail_count = 0;
    int            samples_checked = 0;
    cmh_row_type   rows [7] = '{
        '{CMD_STRENGTH, 24'h3C9868, 8'h3C, 1'b1}, '{CMD_TEMP, 24'h3C9868, 8'h98, 1'b1},
        '{CMD_SUPPLY, 24'h3C9868, 8'h68, 1'b1}, '{CMD_STRENGTH, 24'h007FFF, 8'h00, 1'b1},
        '{CMD_TEMP, 24'h007FFF, 8'h7F, 1'b1}, '{CMD_SUPPLY, 24'h007FFF, 8'hFF, 1'b1},
        '{8'h41, 24'h000000, 8'h00, 1'b0}};

    cmh_handler #(.KEY_GAP_CYCLES(GAP), .MEM_CFG_CYCLES(MCY)) cmh_handler_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .config_pin_i(config_pin_i), .rxd_pin_i(rxd_pin_i),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_ready_i(tx_ready), .sense_i(sense_i),
        .commit_done_i(commit_done_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
        .wr_valid_o(wr_valid_o), .wr_o(wr_o), .commit_o(commit_o), .key_valid_o(key_valid_o),
        .key_data_o(key_data_o), .key_index_o(key_index_o), .key_done_o(key_done_o),
        .key_abort_o(key_abort_o), .sleep_o(sleep_o), .pullup_en_o(pullup_en_o),
        .restart_o(restart_o), .cfg_mode_o(cfg_mode_o));
    cmh_host_model cmh_host_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .slow_i(slow), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .tx_ready_o(tx_ready));

    // ****************************************************************
    // Clock, pulse monitor, watchdog
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Collect pulses driven by the handler
    always @(posedge clk_i) begin
        if (wr_valid_o === 1'b1) wr_q.push_back(wr_o);
        if (key_valid_o === 1'b1) key_q.push_back({key_index_o, key_data_o});
        commit_cnt  += int'(commit_o === 1'b1);
        done_cnt    += int'(key_done_o === 1'b1);
        abort_cnt   += int'(key_abort_o === 1'b1);
        restart_cnt += int'(restart_o === 1'b1);
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            fail_count++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic send(input logic [7:0] b);
        cmh_host_model_inst.send_q.push_back(b);
    endtask

    task automatic reply(input logic [7:0] exp);
        int n;
        n = 0;
        while (cmh_host_model_inst.recv_q.size() == 0 && n < 300) begin
            step(1);
            n++;
        end
        if (n >= 300) chkv(32'hDEAD, {24'h0, exp});
        else chkv(cmh_host_model_inst.recv_q.pop_front(), exp);
    endtask

    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_n_i = 1'b0;
        config_pin_i = 1'b1;
        rxd_pin_i = 1'b1;
        sense_i = '0;
        commit_done_i = 1'b0;
        slow = 1'b0;
        step(3);
        rst_n_i = 1'b1;
        chkv(tx_valid_o, 0);
        chkv(pullup_en_o, 1);
        chkv(cfg_mode_o, 0);
        config_pin_i = 1'b0;
        step(4);
        config_pin_i = 1'b1;
        reply(PROMPT_CHAR);
        chkv(cfg_mode_o, 1);
        for (int i = 0; i < 7; i++) begin
            sense_i = rows[i].sense;
            slow = i[0];
            send(rows[i].cmd);
            if (rows[i].two) reply(rows[i].exp);
            reply(PROMPT_CHAR);
        end
        send(CMD_KEY);
        send(8'h41);
        reply(PROMPT_CHAR);
        send(CMD_CAL_1);
        send(8'h41);
        reply(PROMPT_CHAR);
        send(CMD_MEM_WRITE);
        reply(PROMPT_CHAR);
        foreach (rows[i]) if (i < 5) send(i == 4 ? WRITE_END : 8'h10 + 8'(i));
        step(30);
        chkn(commit_cnt, 1);
        chkn(cmh_host_model_inst.recv_q.size(), 0);
        commit_done_i = 1'b1;
        reply(PROMPT_CHAR);
        chkv(wr_q.pop_front(), 17'h01011);
        chkv(wr_q.pop_front(), 17'h01213);
        send(CMD_CAL_1);
        send(CMD_CAL_2);
        reply(PROMPT_CHAR);
        send(8'h7F);
        send(8'h80);
        send(WRITE_END);
        reply(PROMPT_CHAR);
        chkv(wr_q.pop_front(), 17'h17F80);
        commit_done_i = 1'b0;
        send(CMD_KEY);
        send(KEY_INDEX);
        reply(PROMPT_CHAR);
        for (int k = 0; k < 16; k++) begin
            if (k == 8) step(GAP - 15);
            send(8'hC0 + 8'(k));
        end
        reply(PROMPT_CHAR);
        chkn(abort_cnt, 0);
        chkn(done_cnt, 1);
        chkn(key_q.size(), 16);
        foreach (key_q[k]) chkv(key_q[k], {4'(k), 8'hC0 + 8'(k)});
        chkn(wr_q.size(), 0);
        send(CMD_KEY);
        send(KEY_INDEX);
        reply(PROMPT_CHAR);
        send(8'h01);
        send(8'h02);
        step(GAP + 20);
        chkn(abort_cnt, 1);
        chkn(done_cnt, 1);
        cmh_host_model_inst.recv_q.delete();
        send(CMD_SLEEP_PIN);
        step(10);
        chkv(sleep_o, 0);
        config_pin_i = 1'b0;
        step(5);
        send(CMD_SLEEP_PIN);
        step(26);
        chkv(sleep_o, 1);
        chkv(pullup_en_o, 0);
        config_pin_i = 1'b1;
        step(8);
        chkv(sleep_o, 0);
        chkv(pullup_en_o, 1);
        send(CMD_SLEEP_RX);
        step(26);
        chkv(sleep_o, 1);
        rxd_pin_i = 1'b0;
        step(8);
        chkv(sleep_o, 0);
        rxd_pin_i = 1'b1;
        cmh_host_model_inst.recv_q.delete();
        send(CMD_EXIT);
        step(8);
        chkn(restart_cnt, 1);
        chkv(cfg_mode_o, 0);
        chkn(cmh_host_model_inst.recv_q.size(), 0);
        test_done();
    end
endmodule // tb_top
